/* File: logic/hbrst_top.sv */
// reset sequencing, buffer tri-state control and interrupt pin driver
// assumes both reset pins and the mode pin are asynchronous to mclk_i
`timescale 1ns/10ps

// Overview of operation
// - global reset restores every register default except the global, bus and mode pin synchronisers
// - global reset: no function, outputs high-impedance
// - host bus signals sampled on rising clock
// - interrupt output shows pending internal interrupt
// - mode select low gives mode_select_a interrupt signalling
// - bus reset keeps context bits, clears ordinary bits
// - bus reset: nonfunctional, outputs high-impedance
module hbrst_top
    import hbrst_pkg::*;
#(
    parameter int CTX_W = HBRST_CTX_W,
    parameter int CFG_W = HBRST_CFG_W,
    parameter int IRQ_W = HBRST_IRQ_W
) (
    input wire logic mclk_i,                       // host bus clock
    input wire logic rst_i,                        // core reset, sync high
    input wire logic global_reset_n_i,             // global power reset pin
    input wire logic bus_reset_n_i,                // host bus reset pin
    input wire logic mode_select_a_i,              // low selects mode_select_a
    input wire logic ctx_load_i,                   // load preserved bits
    input wire logic [CTX_W-1:0] ctx_data_i,       // preserved bits data
    input wire logic cfg_load_i,                   // load ordinary bits
    input wire logic [CFG_W-1:0] cfg_data_i,       // ordinary bits data
    input wire logic [IRQ_W-1:0] irq_src_i,        // interrupt conditions
    output logic [CTX_W-1:0] ctx_o,                // preserved bits
    output logic [CFG_W-1:0] cfg_o,                // ordinary bits
    output logic core_run_o,                       // block may operate
    output logic bus_oe_n_o,                       // low: buffers drive
    output logic host_interrupt_out_o,             // interrupt pin level
    output logic host_interrupt_out_oe_n_o,        // low: pin driven
    output logic mode_select_a_mode_o                    // mode_select_a signalling
);
    import hbrst_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [2:0] glb_sync_reg, glb_sync_next;
    logic [2:0] bus_sync_reg, bus_sync_next;
    logic [2:0] mode_sync_reg, mode_sync_next;
    logic glb_ok_reg, glb_ok_next;
    logic bus_ok_reg, bus_ok_next;
    logic cb_mode_reg, cb_mode_next;

    always_comb begin
        glb_sync_next = {glb_sync_reg[1:0], global_reset_n_i};
        bus_sync_next = {bus_sync_reg[1:0], bus_reset_n_i};
        mode_sync_next = {mode_sync_reg[1:0], mode_select_a_i};
        glb_ok_next = glb_ok_reg;
        bus_ok_next = bus_ok_reg;
        cb_mode_next = cb_mode_reg;
        // a change counts once the last two stages agree
        if (glb_sync_reg[1] == glb_sync_reg[2]) begin
            glb_ok_next = glb_sync_reg[2];
        end
        if (bus_sync_reg[1] == bus_sync_reg[2]) begin
            bus_ok_next = bus_sync_reg[2];
        end
        if (mode_sync_reg[1] == mode_sync_reg[2]) begin
            cb_mode_next = ~mode_sync_reg[2];
        end
    end

    // reset pins start out asserted; the mode pin idles high, so no
    // false mode_select_a mode shows while the chain fills after reset
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            glb_sync_reg <= HBRST_SYNC_RST;
            bus_sync_reg <= HBRST_SYNC_RST;
            mode_sync_reg <= HBRST_MODE_SYNC_RST;
            glb_ok_reg <= 1'b0;
            bus_ok_reg <= 1'b0;
            cb_mode_reg <= 1'b0;
        end else begin
            glb_sync_reg <= glb_sync_next;
            bus_sync_reg <= bus_sync_next;
            mode_sync_reg <= mode_sync_next;
            glb_ok_reg <= glb_ok_next;
            bus_ok_reg <= bus_ok_next;
            cb_mode_reg <= cb_mode_next;
        end
    end

    // ****************************************
    // reset sequencing
    // ****************************************
    // raw pins also force the hold so assertion takes effect at once,
    // before the synchroniser has seen it; release waits for sync
    // limitation: a pin falling close to an edge may clear some
    // registers one cycle after others; resets last far longer than
    // that, so every register is cleared by the following edge
    logic glb_hold;
    logic bus_hold;
    hbrst_state_type state_reg, state_next;

    assign glb_hold = ~global_reset_n_i | ~glb_ok_reg;
    assign bus_hold = ~bus_reset_n_i | ~bus_ok_reg;

    // a global hold wins over a bus hold from every state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            HBRST_ST_GLOBAL: begin
                if (!glb_hold) begin
                    state_next = HBRST_ST_BUS;
                end
            end
            HBRST_ST_BUS: begin
                if (glb_hold) begin
                    state_next = HBRST_ST_GLOBAL;
                end else if (!bus_hold) begin
                    state_next = HBRST_ST_RUN;
                end
            end
            HBRST_ST_RUN: begin
                if (glb_hold) begin
                    state_next = HBRST_ST_GLOBAL;
                end else if (bus_hold) begin
                    state_next = HBRST_ST_BUS;
                end
            end
            default: begin
                state_next = HBRST_ST_GLOBAL;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_reg <= HBRST_ST_GLOBAL;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // register storage
    // ****************************************
    // the global power reset is expected once per power-up; a bus
    // reset alone must not wipe the context software saved for wake
    logic [CTX_W-1:0] ctx_reg, ctx_next;
    logic [CFG_W-1:0] cfg_reg, cfg_next;
    logic running;

    // raw pin terms drop running at once, ahead of the state register
    assign running = (state_reg == HBRST_ST_RUN) & ~glb_hold & ~bus_hold;

    always_comb begin
        ctx_next = ctx_reg;
        cfg_next = cfg_reg;
        if (glb_hold) begin
            ctx_next = HBRST_CTX_RST;
            cfg_next = HBRST_CFG_RST;
        end else if (bus_hold) begin
            cfg_next = HBRST_CFG_RST;
        end else if (running) begin
            // loads outside run are dropped with no sign to the user
            if (ctx_load_i) begin
                ctx_next = ctx_data_i;
            end
            if (cfg_load_i) begin
                cfg_next = cfg_data_i;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ctx_reg <= HBRST_CTX_RST;
            cfg_reg <= HBRST_CFG_RST;
        end else begin
            ctx_reg <= ctx_next;
            cfg_reg <= cfg_next;
        end
    end

    // ****************************************
    // interrupt pin
    // ****************************************
    // low cfg bits enable each source; host bus mode is open drain,
    // mode_select_a mode drives the active-low line both ways
    logic [IRQ_W-1:0] irq_en;
    logic irq_any;
    logic irq_pend_reg, irq_pend_next;

    assign irq_en = cfg_reg[IRQ_W-1:0];
    assign irq_any = |(irq_src_i & irq_en);

    always_comb begin
        irq_pend_next = running & irq_any;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            irq_pend_reg <= 1'b0;
        end else begin
            irq_pend_reg <= irq_pend_next;
        end
    end

    // ****************************************
    // output buffers
    // ****************************************
    // an open-drain line is driven only while pulled low; the mode_select_a
    // line is push-pull, so it is driven whenever the block runs
    logic int_drive;

    assign int_drive = cb_mode_reg | irq_pend_reg;
    assign ctx_o = ctx_reg;
    assign cfg_o = cfg_reg;
    assign core_run_o = running;
    assign bus_oe_n_o = ~running;
    assign mode_select_a_mode_o = cb_mode_reg;
    assign host_interrupt_out_o = ~irq_pend_reg;
    assign host_interrupt_out_oe_n_o = ~(running & int_drive);

endmodule : hbrst_top

/* File: logic/hbrst_pkg.sv */
// shared constants for the host bus reset and interrupt pin block
// assumes a single 125 mhz core clock and pins arriving asynchronously
package hbrst_pkg;

    // ****************************************
    // widths and values after reset
    // ****************************************
    localparam int HBRST_CTX_W = 8;
    localparam int HBRST_CFG_W = 8;
    localparam int HBRST_IRQ_W = 4;
    localparam logic [HBRST_CTX_W-1:0] HBRST_CTX_RST = 8'h00;
    localparam logic [HBRST_CFG_W-1:0] HBRST_CFG_RST = 8'h00;
    localparam logic [2:0] HBRST_SYNC_RST = 3'h0;
    localparam logic [2:0] HBRST_MODE_SYNC_RST = 3'h7;

    // ****************************************
    // timing (held by the system, shown for reference)
    // ****************************************
    localparam int HBRST_CLK_PERIOD_PS = 8000;
    localparam int HBRST_GLB_MIN_MS = 2;
    localparam longint HBRST_GLB_MIN_CYC =
        (longint'(HBRST_GLB_MIN_MS) * 64'd1000000000
         + HBRST_CLK_PERIOD_PS - 1) / HBRST_CLK_PERIOD_PS;

    // ****************************************
    // sequencing states, gray along the usual path
    // ****************************************
    typedef enum logic [1:0] {
        HBRST_ST_GLOBAL = 2'b00,
        HBRST_ST_BUS = 2'b01,
        HBRST_ST_RUN = 2'b11
    } hbrst_state_type;

endpackage : hbrst_pkg

/* File: test/hbrst_monitor.sv */
// pin and reset checks for hbrst_top
// assumes one clock; bound at the foot
`timescale 1ns/10ps
module hbrst_monitor #(
    parameter int CTX_W = 8,
    parameter int CFG_W = 8,
    parameter int IRQ_W = 4
) (
    input wire logic mclk_i, // clk
    input wire logic rst_i, // rst
    input wire logic global_reset_n_i, // pin
    input wire logic bus_reset_n_i, // pin
    input wire logic mode_select_a_i, // pin
    input wire logic ctx_load_i, // load
    input wire logic [CTX_W-1:0] ctx_data_i, // data
    input wire logic cfg_load_i, // load
    input wire logic [CFG_W-1:0] cfg_data_i, // data
    input wire logic [IRQ_W-1:0] irq_src_i, // irq
    input wire logic [CTX_W-1:0] ctx_o, // kept
    input wire logic [CFG_W-1:0] cfg_o, // plain
    input wire logic core_run_o, // run
    input wire logic bus_oe_n_o, // oe
    input wire logic host_interrupt_out_o, // int
    input wire logic host_interrupt_out_oe_n_o, // int oe
    input wire logic mode_select_a_mode_o // mode
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    wire logic pend = core_run_o && |(irq_src_i & cfg_o[IRQ_W-1:0]);
    // ****
    // checks
    // ****
    a_glb_hiz: assert property (
        !global_reset_n_i |-> !core_run_o && bus_oe_n_o
        && host_interrupt_out_oe_n_o) else $error("drive in glb rst");
    a_bus_hiz: assert property (
        !bus_reset_n_i |-> !core_run_o && bus_oe_n_o
        && host_interrupt_out_oe_n_o) else $error("drive in bus rst");
    a_glb_clear: assert property (
        !global_reset_n_i |=> ctx_o == '0 && cfg_o == '0)
        else $error("glb rst left bits");
    a_bus_keep: assert property (
        global_reset_n_i && !bus_reset_n_i |=> $stable(ctx_o)
        && cfg_o == '0) else $error("bus rst bits wrong");
    a_cfg_load: assert property (
        core_run_o && cfg_load_i |=> cfg_o == $past(cfg_data_i))
        else $error("load missed");
    a_irq_set: assert property (
        pend |=> !host_interrupt_out_o) else $error("int not shown");
    a_od_high: assert property (
        !mode_select_a_mode_o && host_interrupt_out_o
        |-> host_interrupt_out_oe_n_o) else $error("drove high");
    a_cb_drive: assert property (
        mode_select_a_mode_o && core_run_o |-> !host_interrupt_out_oe_n_o)
        else $error("mode_select_a pin undriven");
endmodule : hbrst_monitor
bind hbrst_top hbrst_monitor #(
    .CTX_W(CTX_W),
    .CFG_W(CFG_W),
    .IRQ_W(IRQ_W)
) u_hbrst_monitor (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .global_reset_n_i(global_reset_n_i),
    .bus_reset_n_i(bus_reset_n_i),
    .mode_select_a_i(mode_select_a_i),
    .ctx_load_i(ctx_load_i),
    .ctx_data_i(ctx_data_i),
    .cfg_load_i(cfg_load_i),
    .cfg_data_i(cfg_data_i),
    .irq_src_i(irq_src_i),
    .ctx_o(ctx_o),
    .cfg_o(cfg_o),
    .core_run_o(core_run_o),
    .bus_oe_n_o(bus_oe_n_o),
    .host_interrupt_out_o(host_interrupt_out_o),
    .host_interrupt_out_oe_n_o(host_interrupt_out_oe_n_o),
    .mode_select_a_mode_o(mode_select_a_mode_o)
);

/* File: test/hbrst_host.sv */
// host bus side: drives both reset pins
// assumes the bench asks for bus resets
`timescale 1ns/10ps
module hbrst_host #(
    parameter int GLB_CYC = 40 // shortened from 2 ms to keep runs short
) (
    input wire logic mclk_i, // clk
    input wire logic bus_req_i, // want bus reset
    output logic global_reset_n_o, // glb pin
    output logic bus_reset_n_o // bus pin
);
    initial begin
        global_reset_n_o = 1'b0;
        repeat (GLB_CYC) @(posedge mclk_i);
        #1 global_reset_n_o = 1'b1;
    end
    // one process owns the bus reset pin; it changes just after an edge
    always @(posedge mclk_i) begin
        bus_reset_n_o <= #1 !bus_req_i;
    end
endmodule : hbrst_host

/* File: test/tb_hbrst_top.sv */
// self-checking bench for hbrst_top
// assumes hbrst_host drives the reset pins
`timescale 1ns/10ps
module tb_hbrst_top;
    import hbrst_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic mode_select_a_i = 1'b1;
    logic ctx_load_i = 1'b0;
    logic cfg_load_i = 1'b0;
    logic bus_req = 1'b0;
    logic [7:0] ctx_data_i = 8'h00;
    logic [7:0] cfg_data_i = 8'h00;
    logic [7:0] ctx_m = 8'h00;
    logic [7:0] cfg_m = 8'h00;
    logic [3:0] irq_src_i = 4'h0;
    logic [31:0] lfsr = 32'hd9ef39ae;
    logic [7:0] ctx_o, cfg_o;
    logic core_run_o, bus_oe_n_o, mode_select_a_mode_o, e;
    logic host_interrupt_out_o, host_interrupt_out_oe_n_o;
    logic global_reset_n_i, bus_reset_n_i;
    int failures = 0;
    int total_checks = 0;
    hbrst_top u_hbrst_top (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .global_reset_n_i(global_reset_n_i),
        .bus_reset_n_i(bus_reset_n_i),
        .mode_select_a_i(mode_select_a_i),
        .ctx_load_i(ctx_load_i),
        .ctx_data_i(ctx_data_i),
        .cfg_load_i(cfg_load_i),
        .cfg_data_i(cfg_data_i),
        .irq_src_i(irq_src_i),
        .ctx_o(ctx_o),
        .cfg_o(cfg_o),
        .core_run_o(core_run_o),
        .bus_oe_n_o(bus_oe_n_o),
        .host_interrupt_out_o(host_interrupt_out_o),
        .host_interrupt_out_oe_n_o(host_interrupt_out_oe_n_o),
        .mode_select_a_mode_o(mode_select_a_mode_o)
    );
    hbrst_host u_hbrst_host (
        .mclk_i(mclk_i),
        .bus_req_i(bus_req),
        .global_reset_n_o(global_reset_n_i),
        .bus_reset_n_o(bus_reset_n_i)
    );
    initial begin
        forever #4 mclk_i = ~mclk_i;
    end
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx
    // active-low pin level expected one edge after sources meet enables
    function automatic logic exp_int_n(input logic [3:0] src,
                                       input logic [3:0] en);
        return ~|(src & en);
    endfunction : exp_int_n
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        total_checks++;
        if (g !== x) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    task automatic tick();
        @(posedge mclk_i);
        #1;
    endtask : tick
    task automatic wait_run();
        repeat (40) if (core_run_o !== 1'b1) tick();
        chk(core_run_o, 1'b1);
    endtask : wait_run
    task automatic results();
        if (failures == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    initial begin
        #(8 * 4000);
        failures++;
        results();
    end
    initial begin
        repeat (16) tick();
        rst_i = 1'b0;
        repeat (4) tick();
        chk(bus_oe_n_o, 1'b1);
        chk(host_interrupt_out_oe_n_o, 1'b1);
        chk(core_run_o, 1'b0);
        wait_run();
        chk(ctx_o, 8'h00);
        chk(cfg_o, 8'h00);
        for (int m = 0; m < 2; m++) begin
            mode_select_a_i = ~m[0];
            repeat (8) tick();
            chk(mode_select_a_mode_o, m[0]);
            for (int i = 0; i < 150; i++) begin
                lfsr = nx(lfsr);
                ctx_load_i = lfsr[0];
                cfg_load_i = lfsr[1] | (i < 2);
                ctx_data_i = lfsr[15:8];
                cfg_data_i = (i < 2) ? 8'h0f : lfsr[23:16];
                irq_src_i = lfsr[27:24] & lfsr[31:28];
                e = exp_int_n(irq_src_i, cfg_m[3:0]);
                tick();
                if (ctx_load_i) ctx_m = ctx_data_i;
                if (cfg_load_i) cfg_m = cfg_data_i;
                chk(ctx_o, ctx_m);
                chk(cfg_o, cfg_m);
                chk(host_interrupt_out_o, e);
                chk(host_interrupt_out_oe_n_o, m[0] ? 1'b0 : e);
            end
        end
        ctx_load_i = 1'b0;
        cfg_load_i = 1'b0;
        bus_req = 1'b1;
        repeat (3) tick();
        chk(bus_oe_n_o, 1'b1);
        chk(host_interrupt_out_oe_n_o, 1'b1);
        bus_req = 1'b0;
        repeat (2) tick();
        wait_run();
        chk(ctx_o, ctx_m);
        chk(cfg_o, 8'h00);
        results();
    end
endmodule : tb_hbrst_top
